// ### hswc_pkg.sv
// Constants and types for the halt, stop and wake control block
//------------------------------------------------------------------------------
// What this block does
// - Pre-divider overflow releases halt when its halt wake enable is set.
// - Timer one underflow or external line change releases halt when enabled.
// - Halt wake enable register holds three bits, written by set-halt-wake op.
// - External line releases stop only with both its stop and halt enables set.
// - Interrupt enable register holds four enables: port C, timer, pin, divider.
// - Set-interrupt-enable op sets or clears each interrupt enable bit.
// - Accepting an interrupt clears its wake request and its interrupt enable.
// - Stop wake enable register holds port C and external line bits.
// - External line stop enable at one lets a pin change release stop.
// - Port C stop enable at one lets a high port C input level release stop.
// - In halt the core stops fetching; only listed circuits keep running.
// - Halt op enters halt only when no release request is pending.
// - Accepted interrupt leaves halt; return from service goes back to halt, or to stop if halt was reached from a stop op.
// - Leaving halt by interrupt clears the matching release request.
// - Port C start condition releases halt when the change enable is set.
// - Enabled timer, pin or divider request releases halt whenever pending.
// - Heavy-load flag set enables an extra parallel crystal buffer stage.
// - Heavy-load flag clear leaves only the normal crystal buffer.
// - Silver-oxide option loads heavy-load flag with one at reset; reset-flag op can clear it.
// - Set-flag op sets, reset-flag op clears heavy-load; halt keeps it.
// - Entering stop sets the heavy-load flag.
// - Release from stop enters halt, then normal halt release applies.
//------------------------------------------------------------------------------
`default_nettype none

package hswc_pkg;
    // Reset values
    localparam logic [2:0] HALT_WAKE_EN_RST = 3'h0;
    localparam logic [3:0] IRQ_EN_RST       = 4'h0;
    localparam logic [1:0] STOP_WAKE_EN_RST = 2'h0;
    localparam logic [3:0] WAKE_REQ_RST     = 4'h0;
    // Source positions in request and interrupt vectors
    localparam int SRC_PORT_C = 0;
    localparam int SRC_TIMER  = 1;
    localparam int SRC_EXT    = 2;
    localparam int SRC_PDIV   = 3;
    // Stop wake enable bit positions
    localparam int STOP_BIT_PORT_C = 0;
    localparam int STOP_BIT_EXT    = 1;

    // Power mode of the core
    typedef enum logic [1:0] {
        MODE_RUN  = 2'b00,
        MODE_HALT = 2'b01,
        MODE_STOP = 2'b10
    } hswc_mode_e;
endpackage

`default_nettype wire

// ### hswc_src_model.sv
// Wake source model: timer, pin, divider and port C events toward the block
`default_nettype none

module hswc_src_model (
    // Clock
    input  wire logic i_clk_sys,
    // Wake events and port C level
    output logic      o_port_c_change,
    output logic      o_timer_one_uf,
    output logic      o_ext_line_edge,
    output logic      o_predivider_ovf,
    output logic      o_port_c_high
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] ev_q = 4'h0;
    logic       hi_q = 1'b0;

    // Events are single-cycle pulses, idle low between them
    assign {o_predivider_ovf, o_ext_line_edge, o_timer_one_uf, o_port_c_change} = ev_q;
    assign o_port_c_high = hi_q;

    // Source index follows the request vector layout
    // Pulse drops on the sampling edge itself, so back-to-back fires never
    // assign the event vector twice in one time step
    task automatic fire(input int s);
        ev_q = 4'h1 << s;
        @(posedge i_clk_sys);
        ev_q <= 4'h0;
        #1;
    endtask

    // Level change takes effect at the next edge
    task automatic hold_high(input logic v);
        hi_q = v;
        @(posedge i_clk_sys);
        #1;
    endtask
endmodule // hswc_src_model

`default_nettype wire

// ### hswc_top.sv
// Halt, stop and wake control: enables, wake requests, power mode, heavy load
`default_nettype none

module hswc_top #(
    parameter bit SILVER_OXIDE = 1'b1  // Power option strap, fixed per build
) (
    // Clock, reset, enable
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    input  wire logic       i_ce,
    // Instruction decoder strobes and operands
    input  wire logic       i_set_halt_wake_op,
    input  wire logic       i_set_irq_en_op,
    input  wire logic       i_set_stop_wake_op,
    input  wire logic       i_set_port_c_change_op,
    input  wire logic       i_clear_wake_req_op,
    input  wire logic       i_set_flag_op,
    input  wire logic       i_reset_flag_op,
    input  wire logic       i_halt_op,
    input  wire logic       i_stop_op,
    input  wire logic       i_return_op,
    input  wire logic [3:0] i_operand,
    // Interrupt acceptance, one-hot by source
    input  wire logic [3:0] i_irq_accept,
    // Wake source events, one-cycle pulses, and port C input level
    input  wire logic       i_port_c_change,
    input  wire logic       i_timer_one_uf,
    input  wire logic       i_ext_line_edge,
    input  wire logic       i_predivider_ovf,
    input  wire logic       i_port_c_high,
    // Status toward core
    output logic [3:0]      o_wake_req,
    output logic [3:0]      o_irq_req,
    output logic            o_port_c_start_cond,
    output logic            o_halted,
    output logic            o_stopped,
    output logic            o_fetch_en,
    output logic            o_heavy_load_flag,
    output logic            o_xtal_extra_buf
);
    //--------------------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------------------
    logic [2:0]          halt_wake_enable_q;
    logic [3:0]          irq_en_bits_q;
    logic [1:0]          stop_wake_enable_q;
    logic                port_c_change_en_q;
    logic [3:0]          wake_req_q;
    logic                heavy_load_flag_q;
    logic                in_service_q;
    hswc_pkg::hswc_mode_e mode_q;
    hswc_pkg::hswc_mode_e resume_q;
    logic [3:0]          irq_req_q;
    logic                start_cond_q;
    logic                xtal_buf_q;

    logic                accept_any;
    logic                halt_release;
    logic                stop_release;
    logic [3:0]          req_set;
    logic [3:0]          req_now;

    //--------------------------------------------------------------------------
    // Combinational conditions
    //--------------------------------------------------------------------------
    // Requests raised this cycle; only port C is gated, by its change enable
    assign req_set[hswc_pkg::SRC_PORT_C] = i_port_c_change & port_c_change_en_q;
    assign req_set[hswc_pkg::SRC_TIMER]  = i_timer_one_uf;
    assign req_set[hswc_pkg::SRC_EXT]    = i_ext_line_edge;
    assign req_set[hswc_pkg::SRC_PDIV]   = i_predivider_ovf;
    // Pending view includes same-cycle events so none is missed
    assign req_now    = wake_req_q | req_set;
    assign accept_any = |i_irq_accept;

    // Enabled halt release: port C start condition or enabled request
    assign halt_release = req_now[hswc_pkg::SRC_PORT_C]
        | (req_now[hswc_pkg::SRC_TIMER] & halt_wake_enable_q[0])
        | (req_now[hswc_pkg::SRC_EXT]   & halt_wake_enable_q[1])
        | (req_now[hswc_pkg::SRC_PDIV]  & halt_wake_enable_q[2]);

    // Stop release: port C level, or pin change with both enables
    assign stop_release =
        (i_port_c_high & stop_wake_enable_q[hswc_pkg::STOP_BIT_PORT_C])
        | (i_ext_line_edge & stop_wake_enable_q[hswc_pkg::STOP_BIT_EXT]
           & halt_wake_enable_q[1]);

    //--------------------------------------------------------------------------
    // Enable registers written by dedicated instructions
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            halt_wake_enable_q <= hswc_pkg::HALT_WAKE_EN_RST;
            stop_wake_enable_q <= hswc_pkg::STOP_WAKE_EN_RST;
            port_c_change_en_q <= 1'b0;
        end else if (i_ce) begin
            if (i_set_halt_wake_op) begin
                halt_wake_enable_q <= i_operand[2:0];
            end
            if (i_set_stop_wake_op) begin
                stop_wake_enable_q <= i_operand[1:0];
            end
            if (i_set_port_c_change_op) begin
                port_c_change_en_q <= i_operand[0];
            end
        end
    end

    // Interrupt enables; acceptance clears its bit, but a write in the
    // same cycle wins since software intends the new value
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_en_bits_q <= hswc_pkg::IRQ_EN_RST;
        end else if (i_ce) begin
            if (i_set_irq_en_op) begin
                irq_en_bits_q <= i_operand;
            end else begin
                irq_en_bits_q <= irq_en_bits_q & ~i_irq_accept;
            end
        end
    end

    //--------------------------------------------------------------------------
    // Wake request flags: new events win over any clear
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            wake_req_q <= hswc_pkg::WAKE_REQ_RST;
        end else if (i_ce) begin
            wake_req_q <= (wake_req_q
                           & ~(i_clear_wake_req_op ? i_operand : 4'h0)
                           & ~i_irq_accept)
                          | req_set;
        end
    end

    //--------------------------------------------------------------------------
    // Power mode sequencing
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_q       <= hswc_pkg::MODE_RUN;
            resume_q     <= hswc_pkg::MODE_RUN;
            in_service_q <= 1'b0;
        end else if (i_ce) begin
            case (mode_q)
                hswc_pkg::MODE_RUN: begin
                    if (accept_any) begin
                        in_service_q <= 1'b1;
                    end else if (i_return_op && in_service_q) begin
                        in_service_q <= 1'b0;
                        mode_q       <= resume_q;
                    end else if (i_stop_op) begin
                        // Pending release turns stop into halt
                        mode_q <= stop_release ? hswc_pkg::MODE_HALT
                                               : hswc_pkg::MODE_STOP;
                    end else if (i_halt_op && !halt_release) begin
                        mode_q   <= hswc_pkg::MODE_HALT;
                        resume_q <= hswc_pkg::MODE_HALT;
                    end else if (i_halt_op) begin
                        resume_q <= hswc_pkg::MODE_RUN;
                    end
                end
                hswc_pkg::MODE_HALT: begin
                    if (accept_any) begin
                        mode_q       <= hswc_pkg::MODE_RUN;
                        in_service_q <= 1'b1;
                    end else if (halt_release) begin
                        mode_q   <= hswc_pkg::MODE_RUN;
                        resume_q <= hswc_pkg::MODE_RUN;
                    end
                end
                hswc_pkg::MODE_STOP: begin
                    if (stop_release) begin
                        mode_q <= hswc_pkg::MODE_HALT;
                    end
                end
                default: begin
                    mode_q <= hswc_pkg::MODE_RUN;
                end
            endcase
            if (mode_q == hswc_pkg::MODE_RUN && i_stop_op && !accept_any
                && !(i_return_op && in_service_q)) begin
                resume_q <= hswc_pkg::MODE_STOP;
            end
        end
    end

    //--------------------------------------------------------------------------
    // Heavy-load flag: stop entry overrides instructions
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            heavy_load_flag_q <= SILVER_OXIDE;
        end else if (i_ce) begin
            if (mode_q == hswc_pkg::MODE_RUN && i_stop_op) begin
                heavy_load_flag_q <= 1'b1;
            end else if (i_set_flag_op) begin
                heavy_load_flag_q <= 1'b1;
            end else if (i_reset_flag_op) begin
                heavy_load_flag_q <= 1'b0;
            end
        end
    end

    //--------------------------------------------------------------------------
    // Registered outputs
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_req_q    <= 4'h0;
            start_cond_q <= 1'b0;
            xtal_buf_q   <= SILVER_OXIDE;
        end else if (i_ce) begin
            irq_req_q    <= wake_req_q & irq_en_bits_q;
            start_cond_q <= wake_req_q[hswc_pkg::SRC_PORT_C];
            // Follows the flag one cycle late; fine for a crystal driver
            xtal_buf_q   <= heavy_load_flag_q;
        end
    end

    assign o_wake_req          = wake_req_q;
    assign o_irq_req           = irq_req_q;
    assign o_port_c_start_cond = start_cond_q;
    assign o_halted            = (mode_q == hswc_pkg::MODE_HALT);
    assign o_stopped           = (mode_q == hswc_pkg::MODE_STOP);
    assign o_fetch_en          = (mode_q == hswc_pkg::MODE_RUN);
    assign o_heavy_load_flag   = heavy_load_flag_q;
    assign o_xtal_extra_buf    = xtal_buf_q;

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    sequence halt_req_pending_s;
        i_ce && mode_q == hswc_pkg::MODE_RUN && i_halt_op && !accept_any
        && !i_stop_op && !(i_return_op && in_service_q);
    endsequence

    halt_entry_a: assert property (halt_req_pending_s |=> (o_halted == !$past(halt_release)))
        else $error("halt entry does not match pending release");
    pdiv_wake_a: assert property (i_ce && o_halted && !accept_any && i_predivider_ovf
        && halt_wake_enable_q[2] |=> o_fetch_en)
        else $error("pre-divider wake missed");
    timer_wake_a: assert property (i_ce && o_halted && !accept_any && i_timer_one_uf
        && halt_wake_enable_q[0] |=> o_fetch_en)
        else $error("timer wake missed");
    accept_clear_a: assert property (i_ce && i_irq_accept[1] && !i_timer_one_uf
        |=> !wake_req_q[1])
        else $error("request not cleared on accept");
    ien_clear_a: assert property (i_ce && i_irq_accept[2] && !i_set_irq_en_op
        |=> !irq_en_bits_q[2])
        else $error("enable not cleared on accept");
    stop_heavy_a: assert property (i_ce && mode_q == hswc_pkg::MODE_RUN && i_stop_op
        |=> o_heavy_load_flag ##1 o_xtal_extra_buf || !i_ce)
        else $error("stop entry did not set heavy load");
    stop_to_halt_a: assert property (i_ce && o_stopped && stop_release |=> o_halted)
        else $error("stop release did not enter halt");
    ext_stop_gate_a: assert property (i_ce && o_stopped && !i_port_c_high
        && !halt_wake_enable_q[1] |=> o_stopped)
        else $error("stop left without both pin enables");
    req_latched_a: assert property (i_ce && wake_req_q[3] && !i_irq_accept[3]
        && !(i_clear_wake_req_op && i_operand[3]) |=> wake_req_q[3])
        else $error("wake request dropped");
    halt_keep_a: assert property (o_halted && !i_stop_op && !i_set_flag_op
        && !i_reset_flag_op |=> $stable(o_heavy_load_flag))
        else $error("heavy load changed in halt");
endmodule // hswc_top

`default_nettype wire

// ### test_halt_stop_wake_control.sv
// Self-checking bench for the halt, stop and wake control block
`default_nettype none

module test_halt_stop_wake_control;
    timeunit 1ns;
    timeprecision 100ps;
    //----------
    // Stimulus and observation
    //----------
    logic       i_clk_sys   = 1'b0;
    logic       i_rstn      = 1'b0;
    logic       ce          = 1'b1;
    logic [9:0] op_q        = 10'h000;
    logic [3:0] opnd        = 4'h0;
    logic [3:0] acc_q       = 4'h0;
    logic       pc_chg, tmr_uf, ext_edge, pdiv_ovf, pc_high;
    logic [3:0] wake, irq, st, aux;
    logic       start_c, halted, stopped, fetch, heavy, xbuf;
    int         err_total   = 0;
    int         check_count = 0;

    // Mode and flags packed so one compare covers them
    assign st  = {stopped, halted, fetch, heavy};
    assign aux = {2'h0, start_c, xbuf};

    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    hswc_src_model src_u (.i_clk_sys(i_clk_sys), .o_port_c_change(pc_chg),
        .o_timer_one_uf(tmr_uf), .o_ext_line_edge(ext_edge),
        .o_predivider_ovf(pdiv_ovf), .o_port_c_high(pc_high));

    // Clock enable driven by the bench so the freeze can be checked
    hswc_top dut_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(ce),
        .i_set_halt_wake_op(op_q[0]), .i_set_irq_en_op(op_q[1]),
        .i_set_stop_wake_op(op_q[2]), .i_set_port_c_change_op(op_q[3]),
        .i_clear_wake_req_op(op_q[4]), .i_set_flag_op(op_q[5]),
        .i_reset_flag_op(op_q[6]), .i_halt_op(op_q[7]), .i_stop_op(op_q[8]),
        .i_return_op(op_q[9]), .i_operand(opnd), .i_irq_accept(acc_q),
        .i_port_c_change(pc_chg), .i_timer_one_uf(tmr_uf),
        .i_ext_line_edge(ext_edge), .i_predivider_ovf(pdiv_ovf),
        .i_port_c_high(pc_high), .o_wake_req(wake), .o_irq_req(irq),
        .o_port_c_start_cond(start_c), .o_halted(halted), .o_stopped(stopped),
        .o_fetch_en(fetch), .o_heavy_load_flag(heavy), .o_xtal_extra_buf(xbuf));
    //----------
    // Shared tasks
    //----------
    task automatic tick;
        @(posedge i_clk_sys);
        #1;
    endtask

    // Decoder strobe k for one cycle with operand v
    // Strobe clears on the sampling edge so a following op starts cleanly
    task automatic op(input int k, input logic [3:0] v);
        op_q = 10'h001 << k;
        opnd = v;
        @(posedge i_clk_sys);
        op_q <= 10'h000;
        #1;
    endtask

    task automatic acc(input logic [3:0] v);
        acc_q = v;
        tick();
        acc_q = 4'h0;
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    //----------
    // Scenarios
    //----------
    task automatic t_flag;
        op(6, 4'h0);
        chk(st, 4'h2, "flag cleared");
        chk(aux, 4'h1, "buffer lags one cycle");
        tick();
        chk(aux, 4'h0, "normal buffer only");
        op(5, 4'h0);
        tick();
        chk(st, 4'h3, "flag set");
        chk(aux, 4'h1, "extra buffer");
        $display("test flag done");
    endtask

    // Clock enable low: ops and events are dropped, state frozen
    task automatic t_freeze;
        ce = 1'b0;
        op(6, 4'h0);
        src_u.fire(1);
        chk(st, 4'h3, "frozen flag");
        chk(aux, 4'h1, "frozen buffer");
        chk(wake, 4'h0, "frozen request");
        ce = 1'b1;
        $display("test freeze done");
    endtask

    // Each enable-gated halt source (timer, pin, divider), with a disabled one firing first
    task automatic t_halt;
        int s;
        int o;
        for (int i = 0; i < 3; i++) begin
            s = i + 1;
            o = s % 3 + 1;
            op(0, 4'(1 << i));
            op(7, 4'h0);
            chk(st, 4'h5, "halted, fetch off, flag kept");
            src_u.fire(o);
            chk(st, 4'h5, "disabled source");
            src_u.fire(s);
            chk(wake, 4'(1 << s) | 4'(1 << o), "requests latched");
            chk(st, 4'h3, "enabled source wakes");
            op(7, 4'h0);
            chk(st, 4'h3, "halt refused");
            op(4, 4'hE);
            chk(wake, 4'h0, "requests cleared");
        end
        $display("test halt done");
    endtask

    task automatic t_portc;
        op(3, 4'h1);
        op(7, 4'h0);
        src_u.fire(0);
        chk(wake, 4'h1, "port C request");
        chk(st, 4'h3, "port C wakes");
        tick();
        chk(aux, 4'h3, "start condition");
        op(4, 4'h1);
        $display("test port C done");
    endtask

    task automatic t_irq;
        op(1, 4'hF);
        for (int s = 0; s < 4; s++) begin
            src_u.fire(s);
            tick();
            chk(irq, 4'(1 << s), "interrupt request");
            acc(4'(1 << s));
            chk(wake, 4'h0, "accept clears request");
        end
        src_u.fire(1);
        tick();
        chk(irq, 4'h0, "enable was cleared");
        op(1, 4'h2);
        op(7, 4'h0);
        tick();
        chk(irq, 4'h2, "request while halted");
        acc(4'h2);
        chk(st, 4'h3, "accept leaves halt");
        chk(wake, 4'h0, "release request cleared");
        op(9, 4'h0);
        chk(st, 4'h5, "return re-enters halt");
        src_u.fire(3);
        chk(st, 4'h3, "divider wakes");
        op(4, 4'h8);
        $display("test interrupt done");
    endtask

    task automatic t_stop;
        op(6, 4'h0);
        op(0, 4'h2);
        op(2, 4'h2);
        op(8, 4'h0);
        chk(st, 4'h9, "stop sets heavy flag");
        src_u.fire(2);
        chk(st, 4'h5, "pin ends stop in halt");
        tick();
        chk(st, 4'h3, "halt release follows");
        op(4, 4'hF);
        op(2, 4'h1);
        op(3, 4'h1);
        op(8, 4'h0);
        src_u.hold_high(1'b1);
        chk(st, 4'h5, "port C ends stop");
        src_u.fire(0);
        chk(st, 4'h3, "port C wakes halt");
        src_u.hold_high(1'b0);
        op(4, 4'hF);
        op(0, 4'h0);
        op(2, 4'h2);
        op(8, 4'h0);
        src_u.fire(2);
        chk(st, 4'h9, "pin needs halt enable too");
        i_rstn = 1'b0;
        tick();
        chk(st, 4'h3, "second reset");
        chk(wake, 4'h0, "requests reset");
        i_rstn = 1'b1;
        $display("test stop done");
    endtask

    // Main sequence: reset held five cycles, then every scenario
    initial begin
        repeat (5) @(posedge i_clk_sys);
        #1;
        chk(st, 4'h3, "reset mode and flag");
        chk(wake, 4'h0, "requests idle");
        chk(aux, 4'h1, "extra buffer in reset");
        i_rstn = 1'b1;
        t_flag();
        t_freeze();
        t_halt();
        t_portc();
        t_irq();
        t_stop();
        summarize();
    end

    // Watchdog: the scenarios need well under 400 cycles
    initial begin
        repeat (3000) @(posedge i_clk_sys);
        err_total++;
        $display("wrong value at %0t: watchdog expired", $time);
        summarize();
    end
endmodule // test_halt_stop_wake_control

`default_nettype wire
